//--- core/rsh_pkg.sv
// Package with register offsets, field positions, reset values and bus constants.
`default_nettype none
package rsh_pkg;
	localparam logic [7:0] ADDR_CONVERTER_STATUS = 8'h01;
	localparam logic [7:0] ADDR_HIGH_SET_ENABLE_AND_LEVEL = 8'h10;
	localparam logic [7:0] ADDR_HIGH_SET_BANK = 8'h1c;
	localparam int THERMAL_TRIP_BIT = 7;
	localparam int OUTPUT_GOOD_BIT = 0;
	localparam int ENABLE_GATE_BIT = 7;
	localparam int LEVEL_CODE_MSB = 6;
	localparam logic [7:0] HIGH_SET_RESET = 8'hff;
	localparam logic [7:0] HIGH_SET_BANK_RESET = 8'h00;
	localparam logic [6:0] LEVEL_CODE_MIN = 7'h0f;
	localparam logic [6:0] LEVEL_CODE_MAX = 7'h7f;
	localparam logic [5:0] STATUS_RESERVED_VALUE = 6'h00;
	localparam logic [6:0] TARGET_ADDRESS = 7'h1c;
	localparam int FAST_MODE_BIT_RATE_KBPS = 400;
	localparam int SYS_CLOCK_KHZ = 10000;
	localparam int FAST_MODE_MIN_BIT_CYCLES = (SYS_CLOCK_KHZ + FAST_MODE_BIT_RATE_KBPS - 1)
		/ FAST_MODE_BIT_RATE_KBPS;
	typedef enum logic [1:0] {RSH_ACC_IDLE, RSH_ACC_WRITE, RSH_ACC_READ} rsh_acc_t;
endpackage : rsh_pkg
`default_nettype wire

//--- core/rsh_acc_if.sv
// Interface carrying one register access between the top and its register store.
`default_nettype none
interface rsh_acc_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] high_set;
	logic [1:0] bank;
	modport store (input wr_en, input addr, input wdata, output high_set, output bank);
	modport user (output wr_en, output addr, output wdata, input high_set, input bank);
endinterface : rsh_acc_if
`default_nettype wire

//--- core/rsh_reg_store.sv
// Storage for the high-set enable, level code and range bank registers.
`default_nettype none
module rsh_reg_store
	import rsh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	rsh_acc_if.store acc
);
	logic [7:0] high_set_r;
	logic [7:0] high_set_nxt;
	logic [1:0] bank_r;
	logic [1:0] bank_nxt;

	// Writes land on the addressed register; every other address leaves both alone.
	always_comb
	begin
		high_set_nxt = high_set_r;
		bank_nxt = bank_r;
		if (acc.wr_en && acc.addr == ADDR_HIGH_SET_ENABLE_AND_LEVEL)
		begin
			high_set_nxt = acc.wdata;
		end
		if (acc.wr_en && acc.addr == ADDR_HIGH_SET_BANK)
		begin
			bank_nxt = acc.wdata[1:0];
		end
	end

	// Values are kept across converter off-state; only power-on reset reloads them (high-set to 8'hff, bank to 0).
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			high_set_r <= HIGH_SET_RESET;
			bank_r <= HIGH_SET_BANK_RESET[1:0];
		end
		else
		begin
			high_set_r <= high_set_nxt;
			bank_r <= bank_nxt;
		end
	end

	assign acc.high_set = high_set_r;
	assign acc.bank = bank_r;
endmodule : rsh_reg_store
`default_nettype wire

//--- core/rsh_regs.sv
// Status and high-set register slice of a step-down regulator control bank.
//
// Contract
// - Status bit 7 reads 1 when junction is above thermal trip, else 0.
// - Status bit 0 reads 1 when output is in range, 0 below ninety percent.
// - With select pin high, high-set bit 7 gates the external enable pin.
// - Converter enables only when enable pin high and gate bit is 1; with select pin low the code follows the enable pin alone.
// - Gate bit 0 keeps converter off even with enable pin high; the code applies this only with select pin high.
// - With select pin high, level code bits 6:0 set output voltage by formula.
// - Range exponent for high-set formula is bits 1:0 of the bank register.
// - Device answers as bus target at seven-bit address 0011100.
// - Bus transfers run at fast mode, at most 400 kbit/s; the host model here issues an access every other clock edge.
`default_nettype none
module rsh_regs
	import rsh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_target,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	input wire logic thermal_trip_in,
	input wire logic output_good_in,
	input wire logic enable_pin,
	input wire logic voltage_set_select_pin,
	output logic converter_enable,
	output logic [6:0] level_code,
	output logic [1:0] range_bank,
	output logic level_code_illegal
);
	rsh_acc_if acc();
	rsh_acc_t acc_r;
	rsh_acc_t acc_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] status_word;
	logic selected;

	// Only accesses addressed to our target address are acted upon.
	assign selected = (reg_target == TARGET_ADDRESS);

	// Status is sampled live from the core; reserved bits read a fixed value.
	assign status_word = {thermal_trip_in, STATUS_RESERVED_VALUE, output_good_in};

	// Writes to the status offset fall through the store's decode and vanish.
	assign acc.wr_en = reg_wr && selected;
	assign acc.addr = reg_addr;
	assign acc.wdata = reg_wdata;

	rsh_reg_store u_store (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.acc(acc.store)
	);

	// Read mux; an unmapped offset answers zero so software sees a defined value.
	always_comb
	begin
		rdata_nxt = rdata_r;
		acc_nxt = RSH_ACC_IDLE;
		if (reg_wr && selected)
		begin
			acc_nxt = RSH_ACC_WRITE;
		end
		else if (reg_rd && selected)
		begin
			acc_nxt = RSH_ACC_READ;
			case (reg_addr)
				ADDR_CONVERTER_STATUS: rdata_nxt = status_word;
				ADDR_HIGH_SET_ENABLE_AND_LEVEL: rdata_nxt = acc.high_set;
				ADDR_HIGH_SET_BANK: rdata_nxt = {6'h00, acc.bank};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Answer register; one cycle after the request the ack pulses.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_r <= RSH_ACC_IDLE;
			rdata_r <= 8'h00;
		end
		else
		begin
			acc_r <= acc_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_ack = (acc_r != RSH_ACC_IDLE);

	// The gate only applies while the select pin is high; the low set is outside this slice,
	// so the pin alone governs there.
	always_comb
	begin
		if (voltage_set_select_pin)
		begin
			converter_enable = enable_pin && acc.high_set[ENABLE_GATE_BIT];
		end
		else
		begin
			converter_enable = enable_pin;
		end
	end

	// Level code and range bank feed the core's reference DAC and feedback divider.
	assign level_code = acc.high_set[LEVEL_CODE_MSB:0];
	assign range_bank = acc.bank;
	// Flags a prohibited code so the core can hold off; the host must never write one.
	assign level_code_illegal = (acc.high_set[LEVEL_CODE_MSB:0] < LEVEL_CODE_MIN);
endmodule : rsh_regs
`default_nettype wire

//--- verif/rsh_regs_asserts.sv
// Checker for the status and high-set register slice.
`default_nettype none
module rsh_regs_asserts
(
	input wire logic clk_sys, nrst, reg_wr, reg_rd, reg_ack, thermal_trip_in, output_good_in,
	input wire logic enable_pin, voltage_set_select_pin, converter_enable, level_code_illegal,
	input wire logic [6:0] reg_target, level_code,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [1:0] range_bank
);
	logic hit;
	logic wr;
	// Only accesses to our own target count; others must be ignored.
	assign hit = (reg_wr | reg_rd) && reg_target == 7'h1c;
	assign wr = hit && reg_wr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_ack; hit |=> reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_stat; hit && !reg_wr && reg_addr == 8'h01
		|=> reg_rdata == {$past(thermal_trip_in), 6'h00, $past(output_good_in)}; endproperty
	a_stat: assert property (p_stat) else $error("status");
	property p_lvl; wr && reg_addr == 8'h10 |=> level_code == $past(reg_wdata[6:0]); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_bank; wr && reg_addr == 8'h1c |=> range_bank == $past(reg_wdata[1:0]); endproperty
	a_bank: assert property (p_bank) else $error("bank");
	property p_gate; wr && reg_addr == 8'h10 && !reg_wdata[7]
		|=> voltage_set_select_pin |-> !converter_enable; endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_pin; !enable_pin |-> !converter_enable; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_ill; level_code_illegal == (level_code < 7'h0f); endproperty
	a_ill: assert property (p_ill) else $error("illegal");
	property p_ro; wr && reg_addr == 8'h01 |=> $stable(level_code); endproperty
	a_ro: assert property (p_ro) else $error("ro");
	c_stat: cover property (hit && reg_addr == 8'h01);
	c_bank: cover property (wr && reg_addr == 8'h1c);
	c_nak: cover property ((reg_wr | reg_rd) && !hit);
endmodule : rsh_regs_asserts
bind rsh_regs rsh_regs_asserts rsh_regs_asserts_inst (.*);
`default_nettype wire

//--- verif/rsh_hst.sv
// Host model issuing single-byte accesses.
`default_nettype none
module rsh_hst
(
	input wire logic clk_sys, reg_ack,
	input wire logic [7:0] reg_rdata,
	output var logic reg_wr = 1'b0, reg_rd = 1'b0,
	output var logic [6:0] reg_target = 7'h1c,
	output var logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released address and data lines invert so stale values never look fresh.
	task automatic xfer(input logic w, input logic [6:0] t, input logic [7:0] a, d,
		output logic k, output logic [7:0] q);
		if (w && a == 8'h10 && d[6:0] < 7'h0f)
			return;
		// At most one access per call, at most every other edge, far faster than the 25-cycle bit time of the bus rate limit.
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_target <= t;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1 k = reg_ack;
		q = reg_rdata;
	endtask : xfer
endmodule : rsh_hst
`default_nettype wire

//--- verif/rsh_regs_test.sv
// Bench for the status and high-set register slice.
`default_nettype none
module rsh_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic thermal_trip_in = 1'b1, output_good_in = 1'b0;
	logic enable_pin = 1'b1, voltage_set_select_pin = 1'b1;
	logic reg_wr, reg_rd, reg_ack, converter_enable, level_code_illegal, k;
	logic [6:0] reg_target, level_code;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic [1:0] range_bank;
	int checks = 0;
	int err_count = 0;
	rsh_regs rsh_regs_inst (.*);
	rsh_hst rsh_hst_inst (.*);
	always #50 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Reset values, flags, and a write to the read-only status.
	task automatic t_stat;
		rsh_hst_inst.xfer(1'b0, 7'h1c, 8'h10, 8'h00, k, q);
		chk("hs", 8'hff, q);
		rsh_hst_inst.xfer(1'b0, 7'h1c, 8'h01, 8'h00, k, q);
		chk("st", 8'h80, q);
		rsh_hst_inst.xfer(1'b1, 7'h1c, 8'h01, 8'h00, k, q);
		chk("ro", 8'h7f, {1'b0, level_code});
		@(posedge clk_sys) thermal_trip_in <= 1'b0;
		@(posedge clk_sys) output_good_in <= 1'b1;
		rsh_hst_inst.xfer(1'b0, 7'h1c, 8'h01, 8'h00, k, q);
		chk("st", 8'h01, q);
		$display("stat done");
	endtask : t_stat
	// Gate bit against the enable pin; bank and foreign target.
	task automatic t_gate;
		rsh_hst_inst.xfer(1'b1, 7'h1c, 8'h10, 8'h0f, k, q);
		chk("ack", 8'h01, {7'h00, k});
		chk("lvl", 8'h0f, {1'b0, level_code});
		chk("ill", 8'h00, {7'h00, level_code_illegal});
		chk("en", 8'h00, {7'h00, converter_enable});
		rsh_hst_inst.xfer(1'b1, 7'h1c, 8'h10, 8'h8f, k, q);
		chk("en", 8'h01, {7'h00, converter_enable});
		@(posedge clk_sys) enable_pin <= 1'b0;
		#1 chk("en", 8'h00, {7'h00, converter_enable});
		rsh_hst_inst.xfer(1'b1, 7'h1c, 8'h1c, 8'h03, k, q);
		rsh_hst_inst.xfer(1'b1, 7'h1d, 8'h1c, 8'h00, k, q);
		chk("ack", 8'h00, {7'h00, k});
		chk("bank", 8'h03, {6'h00, range_bank});
		rsh_hst_inst.xfer(1'b1, 7'h1c, 8'h10, 8'h0f, k, q);
		@(posedge clk_sys)
		begin
			enable_pin <= 1'b1;
			voltage_set_select_pin <= 1'b0;
		end
		#1 chk("en", 8'h01, {7'h00, converter_enable});
		@(posedge clk_sys) voltage_set_select_pin <= 1'b1;
		#1 chk("en", 8'h00, {7'h00, converter_enable});
		$display("gate done");
	endtask : t_gate
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		t_stat();
		t_gate();
		tally_and_finish();
	end
endmodule : rsh_regs_test
`default_nettype wire
